/* tmc_map.svh */
// Register offsets, field positions, masks, reset values and response codes for the timer mode control block
`ifndef TMC_MAP_SVH
`define TMC_MAP_SVH

`define TMC_OFS_CONFIG      12'h000
`define TMC_OFS_A_MODE      12'h004
`define TMC_OFS_B_MODE      12'h008
`define TMC_OFS_CONTROL     12'h00C

`define TMC_CFG_LSB         0
`define TMC_CFG_MSB         2
`define TMC_MODE_LSB        0
`define TMC_MODE_MSB        1
`define TMC_MODE_MASK       32'h0000000F
`define TMC_CFG_MASK        32'h00000007
`define TMC_CTL_MASK        32'h00000F7F

`define TMC_CTL_A_EN        0
`define TMC_CTL_A_FRZ       1
`define TMC_CTL_A_EDGE_LSB  2
`define TMC_CTL_A_EDGE_MSB  3
`define TMC_CTL_CLK_EN      4
`define TMC_CTL_A_TRIG      5
`define TMC_CTL_A_PWM_INV   6
`define TMC_CTL_B_EN        8
`define TMC_CTL_B_FRZ       9
`define TMC_CTL_B_EDGE_LSB  10
`define TMC_CTL_B_EDGE_MSB  11

`define TMC_RST_REG         32'h00000000
`define TMC_RESP_OKAY       2'h0
`define TMC_RESP_SLVERR     2'h2

`endif

/* tmc_pkg.sv */
// Types shared by the timer mode control block
package tmc_pkg;

    // Two-bit half mode encodings
    typedef enum logic [1:0] {
        TMC_MODE_RSVD     = 2'h0,
        TMC_MODE_ONE_SHOT = 2'h1,
        TMC_MODE_PERIODIC = 2'h2,
        TMC_MODE_CAPTURE  = 2'h3
    } tmc_mode_t;

    // Capture edge encodings
    typedef enum logic [1:0] {
        TMC_EDGE_RISE = 2'h0,
        TMC_EDGE_FALL = 2'h1,
        TMC_EDGE_RSVD = 2'h2,
        TMC_EDGE_BOTH = 2'h3
    } tmc_edge_t;

    // Module-wide configuration classes
    typedef enum logic [1:0] {
        TMC_CFG_WIDE   = 2'h0,
        TMC_CFG_CLOCK  = 2'h1,
        TMC_CFG_SPLIT  = 2'h2,
        TMC_CFG_BAD    = 2'h3
    } tmc_cfg_t;

endpackage

/* tmc_half.sv */
// One timer half: mode decode, debug freeze and capture edge detection
`timescale 1ns/100ps
`include "tmc_map.svh"
module tmc_half
    import tmc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       enable,
    input  wire logic       freeze_en,
    input  wire logic       debug_halt,
    input  wire logic       valid_cfg,
    input  wire logic [1:0] mode,
    input  wire logic [1:0] edge_sel,
    input  wire logic       cap_in,
    output logic            run_reg,
    output logic            one_shot_reg,
    output logic            periodic_reg,
    output logic            capture_reg,
    output logic            event_reg
);
    logic cap_d_reg;
    logic mode_ok;
    logic cap_arm;
    logic rise;
    logic fall;
    logic hit;

    // [RULE1] reserved mode rejected
    assign mode_ok = valid_cfg && (mode != TMC_MODE_RSVD);
    assign cap_arm = enable && mode_ok && (mode == TMC_MODE_CAPTURE);
    assign rise    = cap_in && !cap_d_reg;
    assign fall    = !cap_in && cap_d_reg;
    // [RULE5] edge select decode
    assign hit = (edge_sel == TMC_EDGE_RISE) ? rise :
                 (edge_sel == TMC_EDGE_FALL) ? fall :
                 (edge_sel == TMC_EDGE_BOTH) ? (rise || fall) : 1'b0;

    // Registered status; freeze only applies while debug halts the core
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cap_d_reg    <= 1'b0;
            run_reg      <= 1'b0;
            one_shot_reg <= 1'b0;
            periodic_reg <= 1'b0;
            capture_reg  <= 1'b0;
            event_reg    <= 1'b0;
        end else begin
            cap_d_reg    <= cap_in;
            // [RULE6] freeze under halt
            run_reg      <= enable && mode_ok && !(freeze_en && debug_halt);
            one_shot_reg <= mode_ok && (mode == TMC_MODE_ONE_SHOT);
            periodic_reg <= mode_ok && (mode == TMC_MODE_PERIODIC);
            capture_reg  <= mode_ok && (mode == TMC_MODE_CAPTURE);
            event_reg    <= cap_arm && hit;
        end
    end
endmodule

/* tmc_axi_slave.sv */
// AXI4-Lite slave front end: one write and one read at a time
`timescale 1ns/100ps
`include "tmc_map.svh"
module tmc_axi_slave (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             wr_stb,
    output logic [11:0]      wr_addr,
    output logic [31:0]      wr_data,
    output logic [3:0]       wr_strb,
    input  wire logic        wr_ok,
    output logic [11:0]      rd_addr,
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_ok
);
    logic aw_have_reg;
    logic w_have_reg;
    logic [11:0] aw_addr_reg;
    logic aw_take;
    logic w_take;
    logic wr_fire;
    logic ar_take;

    // Ready only while the slot is empty and no response is pending
    assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take  = s_axi_wvalid && s_axi_wready;
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign wr_fire = aw_have_reg && w_have_reg;
    assign wr_stb  = wr_fire;
    assign wr_addr = aw_addr_reg;
    assign rd_addr = s_axi_araddr;

    // Address and data may arrive in either order
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            aw_have_reg  <= 1'b0;
            w_have_reg   <= 1'b0;
            aw_addr_reg  <= 12'h000;
            wr_data      <= 32'h00000000;
            wr_strb      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `TMC_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `TMC_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (w_take) begin
                w_have_reg <= 1'b1;
                wr_data    <= s_axi_wdata;
                wr_strb    <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_have_reg  <= 1'b0;
                w_have_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `TMC_RESP_OKAY : `TMC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_ok ? rd_data : 32'h00000000;
                s_axi_rresp  <= rd_ok ? `TMC_RESP_OKAY : `TMC_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

/* tmc_top.sv */
// Timer mode control: configuration, half modes and control register over AXI4-Lite
`timescale 1ns/100ps
`include "tmc_map.svh"

// What this block does
// [RULE1] Half mode: 1 one-shot, 2 periodic, 3 capture
// [RULE2] Split setup takes half B mode bits
// [RULE3] Wide setup uses half A mode only
// [RULE4] Configuration field decides mode meaning
// [RULE5] Half B edge select rise/fall/both
// [RULE6] Half B freezes under debug halt
// [RULE7] Control bit 8 enables half B
// [RULE8] Control bit 6 inverts half A PWM
// [RULE9] Control bit 5 gates converter trigger
// [RULE10] Converter must enable and select this timer
// [RULE11] Control bit 4 enables clock counting
// [RULE12] Half A edge select, same encoding
// [RULE13] Half A freezes under debug halt
// [RULE14] Control bit 0 enables half A
// [RULE15] Config 0 wide, 1 clock, 4-7 split
// [RULE16] Reserved control bits read zero
module tmc_top
    import tmc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        debug_halt,
    input  wire logic        half_a_cap_pin,
    input  wire logic        half_b_cap_pin,
    input  wire logic        half_a_pwm_raw,
    input  wire logic        half_a_timeout,
    output logic             half_a_run_reg,
    output logic             half_b_run_reg,
    output logic             half_a_one_shot_reg,
    output logic             half_a_periodic_reg,
    output logic             half_a_capture_reg,
    output logic             half_b_one_shot_reg,
    output logic             half_b_periodic_reg,
    output logic             half_b_capture_reg,
    output logic             half_a_event_reg,
    output logic             half_b_event_reg,
    output logic             wide_mode_reg,
    output logic             clock_count_run_reg,
    output logic             half_a_pwm_out_reg,
    output logic             converter_trigger_reg
);
    logic [2:0]  module_configuration_reg;
    logic [3:0]  half_a_mode_register_reg;
    logic [3:0]  half_b_mode_register_reg;
    logic [31:0] module_control_register_reg;
    logic [1:0]  halt_sync_reg;
    logic [1:0]  a_pin_sync_reg;
    logic [1:0]  b_pin_sync_reg;
    logic [1:0]  pwm_sync_reg;
    logic [1:0]  tmo_sync_reg;
    logic        wr_stb;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic [11:0] rd_addr;
    logic [31:0] rd_data;
    logic        wr_ok;
    logic        rd_ok;
    logic [31:0] wmask;
    logic [31:0] ctl_next;
    logic [31:0] cfg_next;
    logic [31:0] amr_next;
    logic [31:0] bmr_next;
    logic        wr_cfg;
    logic        wr_amr;
    logic        wr_bmr;
    logic        wr_ctl;
    tmc_cfg_t    cfg_class;
    logic        split_cfg;
    logic        wide_cfg;
    logic [1:0]  half_b_mode_field;
    logic [1:0]  half_a_mode_field;
    logic [1:0]  b_mode_sel;
    logic        half_a_enable;
    logic        half_a_debug_freeze;
    logic [1:0]  half_a_edge_select;
    logic        clock_count_enable;
    logic        half_a_trigger_enable;
    logic        half_a_pwm_invert;
    logic        half_b_enable;
    logic        half_b_debug_freeze;
    logic [1:0]  half_b_edge_select;
    logic        a_run;
    logic        b_run;

    // Bus front end; the responses come from its flip-flops
    tmc_axi_slave u_bus (
        .clk           (clk),
        .rst_b         (rst_b),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_stb        (wr_stb),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_strb       (wr_strb),
        .wr_ok         (wr_ok),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_ok         (rd_ok)
    );

    // Byte-lane mask from write strobes
    assign wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};

    // Address decode on aligned words
    assign wr_cfg = wr_stb && (wr_addr == `TMC_OFS_CONFIG);
    assign wr_amr = wr_stb && (wr_addr == `TMC_OFS_A_MODE);
    assign wr_bmr = wr_stb && (wr_addr == `TMC_OFS_B_MODE);
    assign wr_ctl = wr_stb && (wr_addr == `TMC_OFS_CONTROL);
    assign wr_ok  = wr_cfg || wr_amr || wr_bmr || wr_ctl;
    assign rd_ok  = (rd_addr == `TMC_OFS_CONFIG) || (rd_addr == `TMC_OFS_A_MODE) ||
                    (rd_addr == `TMC_OFS_B_MODE) || (rd_addr == `TMC_OFS_CONTROL);

    // Merge write data into each register, keeping only implemented bits
    assign cfg_next = ((wr_data & wmask) | ({29'h0, module_configuration_reg} & ~wmask))
                      & `TMC_CFG_MASK;
    assign amr_next = ((wr_data & wmask) | ({28'h0, half_a_mode_register_reg} & ~wmask))
                      & `TMC_MODE_MASK;
    assign bmr_next = ((wr_data & wmask) | ({28'h0, half_b_mode_register_reg} & ~wmask))
                      & `TMC_MODE_MASK;
    // [RULE16] reserved bits dropped
    assign ctl_next = ((wr_data & wmask) | (module_control_register_reg & ~wmask))
                      & `TMC_CTL_MASK;

    // Read mux; unmapped addresses return zero with an error response
    assign rd_data = (rd_addr == `TMC_OFS_CONFIG)  ? {29'h0, module_configuration_reg} :
                     (rd_addr == `TMC_OFS_A_MODE)  ? {28'h0, half_a_mode_register_reg} :
                     (rd_addr == `TMC_OFS_B_MODE)  ? {28'h0, half_b_mode_register_reg} :
                     (rd_addr == `TMC_OFS_CONTROL) ? module_control_register_reg :
                     32'h00000000;

    // Software registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            module_configuration_reg    <= 3'h0;
            half_a_mode_register_reg    <= 4'h0;
            half_b_mode_register_reg    <= 4'h0;
            module_control_register_reg <= `TMC_RST_REG;
        end else begin
            if (wr_cfg)
                module_configuration_reg <= cfg_next[2:0];
            if (wr_amr)
                half_a_mode_register_reg <= amr_next[3:0];
            if (wr_bmr)
                half_b_mode_register_reg <= bmr_next[3:0];
            if (wr_ctl)
                module_control_register_reg <= ctl_next;
        end
    end

    // Control field views
    assign half_a_enable         = module_control_register_reg[`TMC_CTL_A_EN];
    assign half_a_debug_freeze   = module_control_register_reg[`TMC_CTL_A_FRZ];
    assign half_a_edge_select    = module_control_register_reg[`TMC_CTL_A_EDGE_MSB:`TMC_CTL_A_EDGE_LSB];
    assign clock_count_enable    = module_control_register_reg[`TMC_CTL_CLK_EN];
    assign half_a_trigger_enable = module_control_register_reg[`TMC_CTL_A_TRIG];
    assign half_a_pwm_invert     = module_control_register_reg[`TMC_CTL_A_PWM_INV];
    assign half_b_enable         = module_control_register_reg[`TMC_CTL_B_EN];
    assign half_b_debug_freeze   = module_control_register_reg[`TMC_CTL_B_FRZ];
    assign half_b_edge_select    = module_control_register_reg[`TMC_CTL_B_EDGE_MSB:`TMC_CTL_B_EDGE_LSB];
    assign half_a_mode_field     = half_a_mode_register_reg[`TMC_MODE_MSB:`TMC_MODE_LSB];
    assign half_b_mode_field     = half_b_mode_register_reg[`TMC_MODE_MSB:`TMC_MODE_LSB];

    // [RULE15] configuration class decode
    assign cfg_class = (module_configuration_reg == 3'h0) ? TMC_CFG_WIDE :
                       (module_configuration_reg == 3'h1) ? TMC_CFG_CLOCK :
                       module_configuration_reg[2] ? TMC_CFG_SPLIT : TMC_CFG_BAD;
    // [RULE4] mode meaning follows configuration
    assign split_cfg = (cfg_class == TMC_CFG_SPLIT);
    assign wide_cfg  = (cfg_class == TMC_CFG_WIDE);

    // [RULE2] split uses half B field
    // [RULE3] wide ignores half B register
    assign b_mode_sel = split_cfg ? half_b_mode_field : half_a_mode_field;

    // Pin and halt inputs pass two flip-flops before any logic sees them
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            halt_sync_reg  <= 2'h0;
            a_pin_sync_reg <= 2'h0;
            b_pin_sync_reg <= 2'h0;
            pwm_sync_reg   <= 2'h0;
            tmo_sync_reg   <= 2'h0;
        end else begin
            halt_sync_reg  <= {halt_sync_reg[0], debug_halt};
            a_pin_sync_reg <= {a_pin_sync_reg[0], half_a_cap_pin};
            b_pin_sync_reg <= {b_pin_sync_reg[0], half_b_cap_pin};
            pwm_sync_reg   <= {pwm_sync_reg[0], half_a_pwm_raw};
            tmo_sync_reg   <= {tmo_sync_reg[0], half_a_timeout};
        end
    end

    // [RULE14] half A enable, [RULE13] half A freeze, [RULE12] half A edges
    tmc_half u_half_a (
        .clk          (clk),
        .rst_b        (rst_b),
        .enable       (half_a_enable),
        .freeze_en    (half_a_debug_freeze),
        .debug_halt   (halt_sync_reg[1]),
        .valid_cfg    (split_cfg || wide_cfg),
        .mode         (half_a_mode_field),
        .edge_sel     (half_a_edge_select),
        .cap_in       (a_pin_sync_reg[1]),
        .run_reg      (a_run),
        .one_shot_reg (half_a_one_shot_reg),
        .periodic_reg (half_a_periodic_reg),
        .capture_reg  (half_a_capture_reg),
        .event_reg    (half_a_event_reg)
    );

    // [RULE7] half B enable; only a live half in split setup
    tmc_half u_half_b (
        .clk          (clk),
        .rst_b        (rst_b),
        .enable       (half_b_enable),
        .freeze_en    (half_b_debug_freeze),
        .debug_halt   (halt_sync_reg[1]),
        .valid_cfg    (split_cfg),
        .mode         (b_mode_sel),
        .edge_sel     (half_b_edge_select),
        .cap_in       (b_pin_sync_reg[1]),
        .run_reg      (b_run),
        .one_shot_reg (half_b_one_shot_reg),
        .periodic_reg (half_b_periodic_reg),
        .capture_reg  (half_b_capture_reg),
        .event_reg    (half_b_event_reg)
    );

    assign half_a_run_reg = a_run;
    assign half_b_run_reg = b_run;

    // Top-level outputs, each from its own flip-flop
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wide_mode_reg         <= 1'b0;
            clock_count_run_reg   <= 1'b0;
            half_a_pwm_out_reg    <= 1'b0;
            converter_trigger_reg <= 1'b0;
        end else begin
            wide_mode_reg         <= wide_cfg;
            // [RULE11] clock counting enable
            clock_count_run_reg   <= clock_count_enable && (cfg_class == TMC_CFG_CLOCK);
            // [RULE8] PWM inversion
            half_a_pwm_out_reg    <= pwm_sync_reg[1] ^ half_a_pwm_invert;
            // [RULE9] trigger gate; converter side must also select us
            converter_trigger_reg <= tmo_sync_reg[1] && half_a_trigger_enable;
        end
    end
endmodule

/* tmc_top_asserts.sv */
// Checker on tmc_top ports
`timescale 1ns/100ps
module tmc_top_asserts (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        half_a_timeout,
    input wire logic        converter_trigger_reg,
    input wire logic        half_b_one_shot_reg,
    input wire logic        half_b_periodic_reg,
    input wire logic        half_b_capture_reg,
    input wire logic        half_b_run_reg,
    input wire logic        half_a_run_reg,
    input wire logic        wide_mode_reg,
    input wire logic        clock_count_run_reg
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Pending answers
    sequence s_b_wait;
        s_axi_bvalid && !s_axi_bready;
    endsequence
    sequence s_r_wait;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    property p_b_hold;
        s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("b dropped");
    property p_r_hold;
        s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("r dropped");
    // No take while answer pends
    property p_aw_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_aw_block: assert property (p_aw_block) else $error("aw early");
    property p_ar_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("ar early");
    property p_trig;
        converter_trigger_reg |-> $past(half_a_timeout, 3);
    endproperty
    a_trig: assert property (p_trig) else $error("stray trigger");
    property p_b_mode;
        $onehot0({half_b_one_shot_reg, half_b_periodic_reg, half_b_capture_reg});
    endproperty
    a_b_mode: assert property (p_b_mode) else $error("two modes");
    property p_b_run;
        half_b_run_reg |-> half_b_one_shot_reg || half_b_periodic_reg || half_b_capture_reg;
    endproperty
    a_b_run: assert property (p_b_run) else $error("b runs modeless");
    property p_wide;
        wide_mode_reg |-> !half_b_run_reg;
    endproperty
    a_wide: assert property (p_wide) else $error("b runs wide");
    property p_clock;
        clock_count_run_reg |-> !half_a_run_reg && !half_b_run_reg && !wide_mode_reg;
    endproperty
    a_clock: assert property (p_clock) else $error("timer in clock");
endmodule

/* tmc_top_tb.sv */
// Testbench for tmc_top
`timescale 1ns/100ps
`include "tmc_map.svh"
module tmc_top_tb;
    logic        clk, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        debug_halt, half_a_cap_pin, half_b_cap_pin, half_a_pwm_raw, half_a_timeout;
    logic        half_a_run_reg, half_b_run_reg, half_a_one_shot_reg, half_a_periodic_reg;
    logic        half_a_capture_reg, half_b_one_shot_reg, half_b_periodic_reg;
    logic        half_b_capture_reg, half_a_event_reg, half_b_event_reg, wide_mode_reg;
    logic        clock_count_run_reg, half_a_pwm_out_reg, converter_trigger_reg;
    int          bad_count = 0, checks_done = 0, ev_a = 0, ev_b = 0, ea0, eb0;
    logic [2:0]  mode_t [4] = '{3'h0, 3'h4, 3'h2, 3'h1};
    int          cnt_t [4] = '{1, 1, 0, 2};

    tmc_top i_tmc_top (.*);

    // Clock and event counters
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        ev_a <= ev_a + int'(half_a_event_reg === 1'b1);
        ev_b <= ev_b + int'(half_b_event_reg === 1'b1);
    end

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic gap;
        repeat (6) @(posedge clk);
    endtask
    // Bus write, bounded wait
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (n == 50) chk("write wait", 32'h1, 32'h0);
        if (n == 50) end_sim();
        s_axi_bready <= 1'b0;
        chk("bresp", 32'(s_axi_bresp), 32'(er));
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        int n;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (n == 50) chk("read wait", 32'h1, 32'h0);
        if (n == 50) end_sim();
        s_axi_rready <= 1'b0;
        chk("rdata", s_axi_rdata, exp);
        chk("rresp", 32'(s_axi_rresp), 32'(er));
    endtask
    task automatic ctl(input logic [31:0] d);
        wr(`TMC_OFS_CONTROL, d, `TMC_RESP_OKAY);
        gap();
    endtask

    // Main sequence
    initial begin
        {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        s_axi_wstrb = 4'hF;
        {debug_halt, half_a_cap_pin, half_b_cap_pin, half_a_pwm_raw, half_a_timeout} = 5'h00;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        rd(`TMC_OFS_CONTROL, 32'h0, `TMC_RESP_OKAY);
        wr(`TMC_OFS_CONTROL, 32'hFFFFFFFF, `TMC_RESP_OKAY);
        rd(`TMC_OFS_CONTROL, 32'h00000F7F, `TMC_RESP_OKAY);
        wr(12'h010, 32'h1, `TMC_RESP_SLVERR);
        rd(12'h010, 32'h0, `TMC_RESP_SLVERR);
        wr(`TMC_OFS_CONFIG, 32'hFF, `TMC_RESP_OKAY);
        rd(`TMC_OFS_CONFIG, 32'h7, `TMC_RESP_OKAY);
        ctl(32'h101);
        for (int m = 0; m < 4; m++) begin
            wr(`TMC_OFS_CONFIG, 32'(4 + m), `TMC_RESP_OKAY);
            wr(`TMC_OFS_A_MODE, 32'(m), `TMC_RESP_OKAY);
            wr(`TMC_OFS_B_MODE, 32'(m), `TMC_RESP_OKAY);
            gap();
            chk("b modes", {half_b_one_shot_reg, half_b_periodic_reg, half_b_capture_reg}, mode_t[m]);
            chk("a modes", {half_a_one_shot_reg, half_a_periodic_reg, half_a_capture_reg}, mode_t[m]);
            chk("runs", {half_a_run_reg, half_b_run_reg}, (m != 0) ? 2'h3 : 2'h0);
        end
        wr(`TMC_OFS_A_MODE, 32'h2, `TMC_RESP_OKAY);
        wr(`TMC_OFS_B_MODE, 32'h1, `TMC_RESP_OKAY);
        wr(`TMC_OFS_CONFIG, 32'h0, `TMC_RESP_OKAY);
        gap();
        chk("wide", {wide_mode_reg, half_a_periodic_reg, half_b_run_reg, half_a_run_reg}, 4'hD);
        ctl(32'h100);
        chk("a off", half_a_run_reg, 32'h0);
        wr(`TMC_OFS_CONFIG, 32'h1, `TMC_RESP_OKAY);
        ctl(32'h111);
        chk("clock on", {clock_count_run_reg, half_a_run_reg}, 2'h2);
        ctl(32'h101);
        chk("clock off", clock_count_run_reg, 32'h0);
        wr(`TMC_OFS_CONFIG, 32'h2, `TMC_RESP_OKAY);
        ctl(32'h111);
        chk("reserved setup", {clock_count_run_reg, half_a_run_reg, half_b_run_reg}, 3'h0);
        wr(`TMC_OFS_CONFIG, 32'h4, `TMC_RESP_OKAY);
        debug_halt <= 1'b1;
        ctl(32'h303);
        chk("frozen", {half_a_run_reg, half_b_run_reg}, 2'h0);
        ctl(32'h101);
        chk("no freeze", {half_a_run_reg, half_b_run_reg}, 2'h3);
        debug_halt <= 1'b0;
        ctl(32'h303);
        chk("running", {half_a_run_reg, half_b_run_reg}, 2'h3);
        half_a_pwm_raw <= 1'b1;
        half_a_timeout <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            ctl(32'(k) << 5);
            chk("pwm trig", {half_a_pwm_out_reg, converter_trigger_reg}, {~k[1], k[0]});
        end
        wr(`TMC_OFS_A_MODE, 32'h3, `TMC_RESP_OKAY);
        wr(`TMC_OFS_B_MODE, 32'h3, `TMC_RESP_OKAY);
        for (int e = 0; e < 4; e++) begin
            ctl(32'h101 | (32'(e) << 2) | (32'(e) << 10));
            ea0 = ev_a;
            eb0 = ev_b;
            half_a_cap_pin <= 1'b1;
            half_b_cap_pin <= 1'b1;
            gap();
            half_a_cap_pin <= 1'b0;
            half_b_cap_pin <= 1'b0;
            gap();
            chk("a events", ev_a - ea0, cnt_t[e]);
            chk("b events", ev_b - eb0, cnt_t[e]);
        end
        end_sim();
    end
endmodule

bind tmc_top tmc_top_asserts i_tmc_top_asserts (.*);
